// file: fac_pkg.sv
// package: flash host controller constants, commands, pin bundles
package fac_pkg;
  localparam int FAC_AW = 24;
  localparam int FAC_DW = 16;
  // command words and unlock offsets (word and byte mode)
  localparam logic [15:0] FAC_D_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] FAC_D_UNLOCK2 = 16'h0055;
  localparam logic [15:0] FAC_D_IDENT = 16'h0090;
  localparam logic [15:0] FAC_D_PROG = 16'h00a0;
  localparam logic [15:0] FAC_D_EXIT = 16'h00f0;
  localparam logic [23:0] FAC_A_CMD_W = 24'h000555;
  localparam logic [23:0] FAC_A_CMD_B = 24'h000aaa;
  localparam logic [23:0] FAC_A_UNL2_W = 24'h0002aa;
  localparam logic [23:0] FAC_A_UNL2_B = 24'h000555;
  // identification offsets
  localparam logic [23:0] FAC_ID_MFR = 24'h000000;
  localparam logic [23:0] FAC_ID_DEV1 = 24'h000001;
  localparam logic [23:0] FAC_ID_PROT = 24'h000002;
  localparam logic [23:0] FAC_ID_LOCK = 24'h000003;
  localparam logic [23:0] FAC_ID_DEV2 = 24'h00000e;
  localparam logic [23:0] FAC_ID_DEV3 = 24'h00000f;
  localparam logic [7:0] FAC_POLL_BIT = 8'h07;
  // bus-cycle timing, in ns, and cycles at 100 MHz
  localparam int FAC_CLK_NS = 10;
  localparam int FAC_T_SETUP_NS = 35;
  localparam int FAC_T_PULSE_NS = 35;
  localparam int FAC_T_ACC_NS = 90;
  localparam int FAC_SETUP_CYC = (FAC_T_SETUP_NS + FAC_CLK_NS - 1) / FAC_CLK_NS;
  localparam int FAC_PULSE_CYC = (FAC_T_PULSE_NS + FAC_CLK_NS - 1) / FAC_CLK_NS;
  localparam int FAC_ACC_CYC = (FAC_T_ACC_NS + FAC_CLK_NS - 1) / FAC_CLK_NS;
  localparam int FAC_POLL_LIMIT = 100000;

  typedef enum logic [2:0] {
    FAC_OP_IDENT_ENTER = 3'h0,
    FAC_OP_IDENT_READ = 3'h1,
    FAC_OP_IDENT_EXIT = 3'h2,
    FAC_OP_PROGRAM = 3'h3,
    FAC_OP_READ = 3'h4,
    FAC_OP_RESET = 3'h5
  } fac_op_t;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic rst_n;
    logic [23:0] addr;
    logic [15:0] dq_o;
    logic dq_oe_n;
  } fac_pins_t;

  typedef struct packed {
    fac_op_t op;
    logic [23:0] addr;
    logic [15:0] data;
  } fac_req_t;
endpackage

// file: fac_cycle.sv
// single bus-cycle sequencer: one write or one read on the flash pins
`timescale 1ns/1ps
module fac_cycle (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // cycle request
  input wire logic go_in,
  input wire logic wr_in,
  input wire logic [23:0] addr_in,
  input wire logic [15:0] data_in,
  input wire logic [15:0] dq_sync_in,
  // results
  output logic done_out,
  output logic [15:0] rdata_out,
  output fac_pkg::fac_pins_t pins_out
);
  import fac_pkg::*;

  typedef enum logic [1:0] {
    FAC_C_IDLE = 2'h0,
    FAC_C_SETUP = 2'h1,
    FAC_C_PULSE = 2'h2,
    FAC_C_HOLD = 2'h3
  } fac_cst_t;

  fac_cst_t st_r;
  logic [7:0] cnt_r;
  logic wr_r;

  // ---------------------------------
  // pin sequencing
  // ---------------------------------
  always_ff @(posedge clock_in) begin
    done_out <= 1'b0;
    if (srst_in) begin
      st_r <= FAC_C_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      rdata_out <= 16'h0000;
      pins_out <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, rst_n: 1'b1,
                    addr: 24'h000000, dq_o: 16'h0000, dq_oe_n: 1'b1};
    end else begin
      unique case (st_r)
        FAC_C_IDLE: begin
          if (go_in) begin
            wr_r <= wr_in;
            pins_out.addr <= addr_in;
            pins_out.dq_o <= data_in;
            pins_out.oe_n <= 1'b1;
            pins_out.ce_n <= 1'b0;
            pins_out.dq_oe_n <= ~wr_in;
            cnt_r <= 8'(FAC_SETUP_CYC);
            st_r <= FAC_C_SETUP;
          end
        end
        FAC_C_SETUP: begin
          if (cnt_r == 8'h01) begin
            if (wr_r) begin
              pins_out.we_n <= 1'b0;
              cnt_r <= 8'(FAC_PULSE_CYC);
            end else begin
              pins_out.oe_n <= 1'b0;
              cnt_r <= 8'(FAC_ACC_CYC + 2);
            end
            st_r <= FAC_C_PULSE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        FAC_C_PULSE: begin
          if (cnt_r == 8'h01) begin
            // data latched by device on this we rising edge
            pins_out.we_n <= 1'b1;
            pins_out.oe_n <= 1'b1;
            if (!wr_r) rdata_out <= dq_sync_in;
            st_r <= FAC_C_HOLD;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        FAC_C_HOLD: begin
          pins_out.ce_n <= 1'b1;
          pins_out.dq_oe_n <= 1'b1;
          done_out <= 1'b1;
          st_r <= FAC_C_IDLE;
        end
        default: st_r <= FAC_C_IDLE;
      endcase
    end
  end
endmodule

// file: fac_host.sv
// host controller for parallel flash: identification and single-word program
`timescale 1ns/1ps
// Operation
// - identify entry: AA@555, 55@2AA, 90@555
// - write F0 anywhere to leave identification
// - writes: ce, we low, oe high
// - program: AA, 55, A0, then address/data
// - hardware reset aborts programming
// - after failure host issues reset command
module fac_host #(
  parameter int POLL_LIMIT = fac_pkg::FAC_POLL_LIMIT
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // command port
  input wire logic req_valid_in,
  input wire fac_pkg::fac_req_t req_in,
  input wire logic byte_mode_in,
  input wire logic skip_unlock_in,
  output logic req_ready_out,
  output logic resp_valid_out,
  output logic [15:0] resp_data_out,
  output logic resp_fail_out,
  // flash pins
  input wire logic [15:0] dq_in,
  output fac_pkg::fac_pins_t pins_out
);
  import fac_pkg::*;

  typedef enum logic [2:0] {
    FAC_IDLE = 3'h0,
    FAC_SEQ = 3'h1,
    FAC_POLL = 3'h2,
    FAC_RESET = 3'h3,
    FAC_DONE = 3'h4
  } fac_st_t;

  fac_st_t st_r;
  fac_req_t req_r;
  logic byte_r;
  logic skip_r;
  logic [2:0] step_r;
  logic [31:0] poll_r;
  logic [15:0] dq_s1_r;
  logic [15:0] dq_s2_r;
  logic go_r;
  logic wr_r;
  logic [23:0] ca_r;
  logic [15:0] cd_r;
  logic cdone;
  logic [15:0] crdata;
  fac_pins_t cpins;
  logic [3:0] rst_cnt_r;

  // word-mode offset replaced by its byte-mode value in byte mode (555 to AAA, 2AA to 555)
  function automatic logic [23:0] fac_off(input logic bm, input logic [23:0] w,
                                          input logic [23:0] b);
    fac_off = bm ? b : w;
  endfunction

  // ---------------------------------
  // pin input synchroniser
  // ---------------------------------
  always_ff @(posedge clock_in) begin
    dq_s1_r <= dq_in;
    dq_s2_r <= dq_s1_r;
  end

  fac_cycle u_cycle (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .go_in(go_r),
    .wr_in(wr_r),
    .addr_in(ca_r),
    .data_in(cd_r),
    .dq_sync_in(dq_s2_r),
    .done_out(cdone),
    .rdata_out(crdata),
    .pins_out(cpins)
  );

  // ---------------------------------
  // pins: hardware reset overrides cycle
  // ---------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pins_out <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, rst_n: 1'b1,
                    addr: 24'h000000, dq_o: 16'h0000, dq_oe_n: 1'b1};
    end else begin
      pins_out <= cpins;
      pins_out.rst_n <= ~(st_r == FAC_RESET);
    end
  end

  // ---------------------------------
  // sequencer
  // ---------------------------------
  always_ff @(posedge clock_in) begin
    go_r <= 1'b0;
    resp_valid_out <= 1'b0;
    if (srst_in) begin
      st_r <= FAC_IDLE;
      req_r <= '{op: FAC_OP_READ, addr: 24'h000000, data: 16'h0000};
      byte_r <= 1'b0;
      skip_r <= 1'b0;
      step_r <= 3'h0;
      poll_r <= 32'h0;
      wr_r <= 1'b0;
      ca_r <= 24'h000000;
      cd_r <= 16'h0000;
      req_ready_out <= 1'b0;
      resp_data_out <= 16'h0000;
      resp_fail_out <= 1'b0;
      rst_cnt_r <= 4'h0;
    end else begin
      unique case (st_r)
        FAC_IDLE: begin
          req_ready_out <= 1'b1;
          if (req_valid_in && req_ready_out) begin
            req_ready_out <= 1'b0;
            req_r <= req_in;
            byte_r <= byte_mode_in;
            skip_r <= skip_unlock_in;
            resp_fail_out <= 1'b0;
            step_r <= 3'h0;
            if (req_in.op == FAC_OP_RESET) begin
              rst_cnt_r <= 4'hf;
              st_r <= FAC_RESET;
            end else begin
              st_r <= FAC_SEQ;
            end
          end
        end
        FAC_SEQ: begin
          if (step_r == 3'h0 || cdone) begin
            step_r <= step_r + 3'h1;
            go_r <= 1'b1;
            wr_r <= 1'b1;
            unique case (req_r.op)
              FAC_OP_IDENT_ENTER, FAC_OP_PROGRAM: begin
                if (req_r.op == FAC_OP_PROGRAM && skip_r && step_r < 3'h2)
                  step_r <= 3'h3;
                if (step_r == 3'h0 && !(req_r.op == FAC_OP_PROGRAM && skip_r)) begin
                  ca_r <= fac_off(byte_r, FAC_A_CMD_W, FAC_A_CMD_B);
                  cd_r <= FAC_D_UNLOCK1;
                end else if (step_r == 3'h1) begin
                  ca_r <= fac_off(byte_r, FAC_A_UNL2_W, FAC_A_UNL2_B);
                  cd_r <= FAC_D_UNLOCK2;
                end else if (step_r == 3'h2 || (step_r == 3'h0 && skip_r)) begin
                  ca_r <= fac_off(byte_r, FAC_A_CMD_W, FAC_A_CMD_B);
                  cd_r <= (req_r.op == FAC_OP_IDENT_ENTER) ? FAC_D_IDENT : FAC_D_PROG;
                  if (req_r.op == FAC_OP_IDENT_ENTER) step_r <= 3'h5;
                end else if (step_r == 3'h3) begin
                  ca_r <= req_r.addr;
                  cd_r <= byte_r ? {8'h00, req_r.data[7:0]} : req_r.data;
                end else if (step_r == 3'h4) begin
                  wr_r <= 1'b0;
                  ca_r <= req_r.addr;
                  poll_r <= 32'h0;
                  st_r <= FAC_POLL;
                end else begin
                  go_r <= 1'b0;
                  st_r <= FAC_DONE;
                end
              end
              FAC_OP_IDENT_EXIT: begin
                if (step_r == 3'h0) begin
                  ca_r <= req_r.addr;
                  cd_r <= FAC_D_EXIT;
                end else begin
                  go_r <= 1'b0;
                  st_r <= FAC_DONE;
                end
              end
              default: begin
                if (step_r == 3'h0) begin
                  wr_r <= 1'b0;
                  ca_r <= req_r.addr;
                end else begin
                  go_r <= 1'b0;
                  resp_data_out <= byte_r ? {8'h00, crdata[7:0]} : crdata;
                  st_r <= FAC_DONE;
                end
              end
            endcase
          end
        end
        FAC_POLL: begin
          if (cdone) begin
            if (crdata[FAC_POLL_BIT[3:0]] == req_r.data[FAC_POLL_BIT[3:0]]) begin
              resp_data_out <= crdata;
              st_r <= FAC_DONE;
            end else if (poll_r >= 32'(POLL_LIMIT)) begin
              resp_fail_out <= 1'b1;
              req_r.op <= FAC_OP_IDENT_EXIT;
              step_r <= 3'h0;
              st_r <= FAC_SEQ;
            end else begin
              poll_r <= poll_r + 32'h1;
              go_r <= 1'b1;
            end
          end
        end
        FAC_RESET: begin
          rst_cnt_r <= rst_cnt_r - 4'h1;
          if (rst_cnt_r == 4'h1) st_r <= FAC_DONE;
        end
        FAC_DONE: begin
          resp_valid_out <= 1'b1;
          st_r <= FAC_IDLE;
        end
        default: st_r <= FAC_IDLE;
      endcase
    end
  end
endmodule

// file: fac_host_props.sv
// checker: port-level properties of the flash host controller
`timescale 1ns/1ps
module fac_host_props (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // command port
  input wire logic req_valid_in,
  input wire fac_pkg::fac_req_t req_in,
  input wire logic byte_mode_in,
  input wire logic skip_unlock_in,
  input wire logic req_ready_out,
  input wire logic resp_valid_out,
  input wire logic resp_fail_out,
  // flash pins
  input wire fac_pkg::fac_pins_t pins_out
);
  import fac_pkg::*;
  logic f0_seen_r;
  wire wr = !pins_out.we_n;
  wire take = req_valid_in && req_ready_out;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // ----
  // helper: reset command seen since the request was taken
  // ----
  always_ff @(posedge clock_in) begin
    if (srst_in || take) f0_seen_r <= 1'b0;
    else if (wr && pins_out.dq_o[7:0] == FAC_D_EXIT[7:0]) f0_seen_r <= 1'b1;
  end
  write_pins_a: assert property (wr |-> !pins_out.ce_n && pins_out.oe_n &&
    !pins_out.dq_oe_n) else $error("write without ce low, oe high and dq driven");
  no_contend_a: assert property (!pins_out.oe_n |-> pins_out.dq_oe_n)
    else $error("host drives dq during a read");
  latch_hold_a: assert property (wr && $past(wr) |->
    $stable(pins_out.addr) && $stable(pins_out.dq_o)) else $error("addr or data moved");
  we_width_a: assert property ($fell(pins_out.we_n) |-> !pins_out.we_n[*4])
    else $error("write strobe too short");
  hw_reset_a: assert property ($fell(pins_out.rst_n) |-> !pins_out.rst_n[*8])
    else $error("reset pulse too short");
  fail_exit_a: assert property (resp_valid_out && resp_fail_out |-> f0_seen_r)
    else $error("timeout reported without reset command");
  ident_start_a: assert property (take && req_in.op == FAC_OP_IDENT_ENTER |-> ##[1:30]
    (wr && pins_out.dq_o[7:0] == 8'haa &&
    pins_out.addr == (byte_mode_in ? FAC_A_CMD_B : FAC_A_CMD_W))) else $error("no unlock");
  prog_start_a: assert property (take && req_in.op == FAC_OP_PROGRAM |-> ##[1:30]
    (wr && pins_out.dq_o[7:0] == (skip_unlock_in ? 8'ha0 : 8'haa)))
    else $error("program sequence start wrong");
  exit_cmd_a: assert property (take && req_in.op == FAC_OP_IDENT_EXIT |-> ##[1:30]
    (wr && pins_out.dq_o[7:0] == 8'hf0)) else $error("no exit command written");
  resp_once_a: assert property (resp_valid_out |=> !resp_valid_out)
    else $error("response longer than one cycle");
  cover property (take && req_in.op == FAC_OP_PROGRAM && skip_unlock_in);
  cover property (resp_valid_out && resp_fail_out);
  cover property (take && req_in.op == FAC_OP_IDENT_ENTER && byte_mode_in);
endmodule
bind fac_host fac_host_props u_props (.clock_in(clock_in), .srst_in(srst_in),
  .req_valid_in(req_valid_in), .req_in(req_in), .byte_mode_in(byte_mode_in),
  .skip_unlock_in(skip_unlock_in), .req_ready_out(req_ready_out),
  .resp_valid_out(resp_valid_out), .resp_fail_out(resp_fail_out), .pins_out(pins_out));

// file: fac_flash_model.sv
// behavioural parallel flash: command decoder, identification, word program
`timescale 1ns/1ps
module fac_flash_model #(
  parameter logic [15:0] ID_MFR = 16'h00c3, // arbitrary
  parameter logic [15:0] ID_DEV1 = 16'h5a11, // arbitrary
  parameter logic [15:0] ID_DEV2 = 16'h5a22, // arbitrary
  parameter logic [15:0] ID_DEV3 = 16'h5a33, // arbitrary
  parameter logic [15:0] LOCK_CODE = 16'h0019,
  parameter logic [7:0] PROT_SEC = 8'h01,
  parameter int PROG_NS = 400
) (
  // pins from host
  input wire fac_pkg::fac_pins_t pins_in,
  input wire logic byte_in,
  input wire logic bypass_in,
  input wire logic stuck_in,
  // data pins back to host
  output logic [15:0] dq_out
);
  import fac_pkg::*;
  logic [15:0] mem [logic [23:0]];
  logic [23:0] a_r = 24'h000000;
  logic [15:0] prog_word_r = 16'h0000;
  logic [15:0] last_r = 16'h0000;
  logic [15:0] rv;
  logic busy_r = 1'b0;
  logic idm_r = 1'b0;
  logic tog_r = 1'b0;
  int st_r = 0;
  int tok_r = 0;
  wire wr_n = pins_in.ce_n | pins_in.we_n;
  function automatic logic [15:0] peek(logic [23:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  always @* begin
    if (busy_r) rv = {8'h00, ~prog_word_r[7], tog_r, 6'h00};
    else if (idm_r) case (pins_in.addr[7:0])
      8'h00: rv = ID_MFR;
      8'h01: rv = ID_DEV1;
      8'h0e: rv = ID_DEV2;
      8'h0f: rv = ID_DEV3;
      8'h03: rv = LOCK_CODE;
      8'h02: rv = {15'h0000, pins_in.addr[23:16] == PROT_SEC};
      default: rv = 16'h0000;
    endcase
    else rv = peek(pins_in.addr);
    if (byte_in) rv[15:8] = 8'h00;
  end
  // no pull on dq: a released bus shows the inverse of the last value
  assign dq_out = (!pins_in.ce_n && !pins_in.oe_n) ? rv : ~last_r;
  always @(posedge pins_in.oe_n) last_r = rv;
  always @(negedge pins_in.oe_n) if (busy_r) tog_r = ~tog_r;
  always @(negedge wr_n) a_r = pins_in.addr;
  always @(posedge wr_n or negedge pins_in.rst_n) begin
    logic [7:0] d;
    logic [23:0] ca;
    logic [23:0] ua;
    d = pins_in.dq_o[7:0];
    ca = byte_in ? FAC_A_CMD_B : FAC_A_CMD_W;
    ua = byte_in ? FAC_A_UNL2_B : FAC_A_UNL2_W;
    if (!pins_in.rst_n) begin
      busy_r = 1'b0; idm_r = 1'b0; st_r = 0; tok_r++;
    end else if (busy_r) begin
      if (stuck_in && d == 8'hf0) busy_r = 1'b0;
    end else if (st_r == 3) begin
      prog_word_r = pins_in.dq_o; st_r = 0; busy_r = 1'b1; tok_r++;
      if (!stuck_in) begin
        mem[a_r] = peek(a_r) & (byte_in ? {8'hff, d} : pins_in.dq_o);
        fork
          begin
            automatic int t = tok_r;
            #(PROG_NS) if (t == tok_r) busy_r = 1'b0;
          end
        join_none
      end
    end else if (d == 8'hf0) begin
      idm_r = 1'b0; st_r = 0;
    end else if (st_r == 0 && a_r == ca && d == 8'haa) st_r = 1;
    else if (st_r == 0 && bypass_in && d == 8'ha0) st_r = 3;
    else if (st_r == 1 && a_r == ua && d == 8'h55) st_r = 2;
    else if (st_r == 2 && a_r == ca && d == 8'h90) begin
      idm_r = 1'b1; st_r = 0;
    end else if (st_r == 2 && a_r == ca && d == 8'ha0) st_r = 3;
    else st_r = 0;
  end
endmodule

// file: tb_fac_host.sv
// self-checking bench: flash host controller against a flash model
`timescale 1ns/1ps
module tb_fac_host;
  import fac_pkg::*;
  localparam logic [15:0] ID_MFR = 16'h00c3; // arbitrary
  localparam logic [15:0] ID_DEV1 = 16'h5a11; // arbitrary
  localparam logic [15:0] ID_DEV2 = 16'h5a22; // arbitrary
  localparam logic [15:0] ID_DEV3 = 16'h5a33; // arbitrary
  localparam logic [15:0] LOCK_CODE = 16'h0019;
  localparam logic [7:0] PROT_SEC = 8'h01;
  logic clock_in, srst_in, req_valid_in, byte_mode_in, skip_unlock_in, stuck;
  logic req_ready_out, resp_valid_out, resp_fail_out;
  logic [15:0] resp_data_out, mdq, d;
  logic [23:0] a;
  fac_req_t req_in;
  fac_pins_t pins_out;
  wire [15:0] dq_in = pins_out.dq_oe_n ? mdq : pins_out.dq_o;
  int n_fail, check_count, seed;
  logic [15:0] ref_mem [logic [23:0]];
  fac_host #(.POLL_LIMIT(20)) uut (.clock_in(clock_in), .srst_in(srst_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .byte_mode_in(byte_mode_in),
    .skip_unlock_in(skip_unlock_in), .req_ready_out(req_ready_out),
    .resp_valid_out(resp_valid_out), .resp_data_out(resp_data_out),
    .resp_fail_out(resp_fail_out), .dq_in(dq_in), .pins_out(pins_out));
  fac_flash_model #(.ID_MFR(ID_MFR), .ID_DEV1(ID_DEV1), .ID_DEV2(ID_DEV2),
    .ID_DEV3(ID_DEV3), .LOCK_CODE(LOCK_CODE), .PROT_SEC(PROT_SEC)) u_flash (
    .pins_in(pins_out), .byte_in(byte_mode_in), .bypass_in(skip_unlock_in),
    .stuck_in(stuck), .dq_out(mdq));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // ----
  // tasks
  // ----
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(fac_op_t o, logic [23:0] ad, logic [15:0] dt);
    int n;
    req_valid_in = 1'b1;
    req_in = '{o, ad, dt};
    n = 0;
    while (req_ready_out !== 1'b1 && n < 100) begin @(posedge clock_in); #1; n++; end
    if (n >= 100) begin n_fail++; $display("BAD t=%0t never ready", $time); end
    @(posedge clock_in);
    #1 req_valid_in = 1'b0;
    n = 0;
    while (resp_valid_out !== 1'b1 && n < 3000) begin @(posedge clock_in); #1; n++; end
    if (n >= 3000) begin n_fail++; $display("BAD t=%0t no response", $time); end
  endtask
  function automatic logic [15:0] peek(logic [23:0] ad);
    logic [15:0] v;
    v = ref_mem.exists(ad) ? ref_mem[ad] : 16'hffff;
    return byte_mode_in ? {8'h00, v[7:0]} : v;
  endfunction
  task automatic rchk(fac_op_t o, logic [23:0] ad, logic [15:0] e);
    op(o, ad, 16'h0000);
    chk(resp_data_out, e);
  endtask
  task automatic prog(logic [23:0] ad, logic [15:0] dt);
    op(FAC_OP_PROGRAM, ad, dt);
    ref_mem[ad] = (ref_mem.exists(ad) ? ref_mem[ad] : 16'hffff)
      & (byte_mode_in ? {8'hff, dt[7:0]} : dt);
    chk({15'h0000, resp_fail_out}, 16'h0000);
    chk(resp_data_out, peek(ad));
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    $display("BAD t=%0t watchdog expired", $time);
    finish_test;
  end
  initial begin
    seed = 73815; n_fail = 0; check_count = 0; stuck = 1'b0;
    srst_in = 1'b1; req_valid_in = 1'b0; req_in = '0;
    byte_mode_in = 1'b0; skip_unlock_in = 1'b0;
    repeat (6) @(posedge clock_in);
    #1 srst_in = 1'b0;
    op(FAC_OP_IDENT_ENTER, 24'h000000, 16'h0000);
    rchk(FAC_OP_IDENT_READ, FAC_ID_MFR, ID_MFR);
    rchk(FAC_OP_IDENT_READ, FAC_ID_MFR, ID_MFR);
    rchk(FAC_OP_IDENT_READ, FAC_ID_DEV1, ID_DEV1);
    rchk(FAC_OP_IDENT_READ, FAC_ID_DEV2, ID_DEV2);
    rchk(FAC_OP_IDENT_READ, FAC_ID_DEV3, ID_DEV3);
    rchk(FAC_OP_IDENT_READ, FAC_ID_LOCK, LOCK_CODE);
    rchk(FAC_OP_IDENT_READ, {PROT_SEC, 16'h0002}, 16'h0001);
    rchk(FAC_OP_IDENT_READ, 24'h020002, 16'h0000);
    op(FAC_OP_IDENT_EXIT, 24'h123456, 16'h0000);
    rchk(FAC_OP_READ, FAC_ID_DEV1, 16'hffff);
    byte_mode_in = 1'b1;
    op(FAC_OP_IDENT_ENTER, 24'h000000, 16'h0000);
    rchk(FAC_OP_IDENT_READ, FAC_ID_DEV1, {8'h00, ID_DEV1[7:0]});
    op(FAC_OP_RESET, 24'h000000, 16'h0000);
    rchk(FAC_OP_READ, FAC_ID_DEV1, 16'h00ff);
    $display("test identification done");
    // bit 7 kept low so completion polling can match
    for (int i = 0; i < 6; i++) begin
      byte_mode_in = (i == 4);
      skip_unlock_in = (i == 5);
      a = 24'($random(seed));
      d = 16'($random(seed)) & 16'hff7f;
      prog(a, d);
      prog(a, 16'($random(seed)) & 16'hff7f);
      rchk(FAC_OP_READ, a, peek(a));
    end
    byte_mode_in = 1'b0;
    skip_unlock_in = 1'b0;
    $display("test program done");
    stuck = 1'b1;
    op(FAC_OP_PROGRAM, a, 16'h0000);
    chk({15'h0000, resp_fail_out}, 16'h0001);
    stuck = 1'b0;
    rchk(FAC_OP_READ, a, peek(a));
    prog(24'h7f0010, 16'h1234);
    $display("test timeout done");
    finish_test;
  end
endmodule
